// File: rtl/ifm_pkg.sv
// Constants, types and register map of the input fault monitor
// ---------------------------------------------------------------------
// What this block does
// - Two independent fault outputs, one per input.
// - Audio faults need full fault duration first.
// - Fault drops within release delay, default one second.
// - Auto mode lets faults drive switch-over.
// - Programmable fault duration per input.
// - Enables for video loss, freeze, black.
// - Four audio group loss enables.
// - Four audio pair over-level enables.
// - Four audio pair silence enables.
// - Four audio pair phase reversal enables.
// - Four audio pair mono enables.
// - Enable for invalid video fault.
// - Enables for sync loss, sync error.
// - Enables for minimum and maximum bit rate.
// - Enables for null packets, continuity errors.
// - Enables for three PID checks.
// - Enable for missing PAT table.
// - Duration 1..255 frames, default 30, 50 ms.
// - OR or AND combination, OR default.
// - Video loss unqualified; invalid video own duration.
// ---------------------------------------------------------------------
package ifm_pkg;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int UNIT_TIME_MS   = 50;
  localparam int UNIT_CYCLES    = UNIT_TIME_MS * CLK_MHZ * 1000;
  localparam int RELEASE_TIME_MS = 1000;
  localparam logic [7:0] RELEASE_RST =
    8'(RELEASE_TIME_MS / UNIT_TIME_MS);
  localparam logic [7:0] HOLD_RST   = 8'h1E;
  localparam logic [7:0] VHOLD_RST  = 8'h1E;
  localparam logic [7:0] CNT_MAX    = 8'hFF;

  // -------------------------------------------------------------------
  // Condition bit positions
  // -------------------------------------------------------------------
  localparam int NCOND        = 34;
  localparam int C_VLOSS      = 0;
  localparam int C_VFREEZE    = 1;
  localparam int C_VBLACK     = 2;
  localparam int C_VINVALID   = 3;
  localparam int C_AUD_FIRST  = 4;
  localparam int NAUD         = 20;
  localparam int C_GRP_LOSS   = 4;
  localparam int C_PAIR_OVER  = 8;
  localparam int C_PAIR_SIL   = 12;
  localparam int C_PAIR_PHASE = 16;
  localparam int C_PAIR_MONO  = 20;
  localparam int C_TS_SLOSS   = 24;
  localparam int C_TS_SERR    = 25;
  localparam int C_TS_MINRATE = 26;
  localparam int C_TS_MAXRATE = 27;
  localparam int C_TS_NULL    = 28;
  localparam int C_TS_CC      = 29;
  localparam int C_TS_MINPID  = 30;
  localparam int C_TS_PIDCNT  = 31;
  localparam int C_TS_PIDLIST = 32;
  localparam int C_TS_NOPAT   = 33;

  // -------------------------------------------------------------------
  // Register map (byte addresses)
  // -------------------------------------------------------------------
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IN_BASE = 8'h10;
  localparam logic [7:0] A_IN_STEP = 8'h10;
  localparam logic [7:0] A_EN_LO   = 8'h00;
  localparam logic [7:0] A_EN_HI   = 8'h04;
  localparam logic [7:0] A_TIME    = 8'h08;

  // CTRL fields
  localparam int F_SWITCH_MODE_SELECT   = 0;
  localparam int F_MANSEL = 1;
  localparam int F_ASI    = 2;
  // TIME fields
  localparam int F_HOLD   = 0;
  localparam int F_VHOLD  = 8;
  localparam int F_REL    = 16;
  localparam int F_LOGIC  = 24;

  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef enum logic [0:0] {
    IFM_COMB_OR  = 1'b0,
    IFM_COMB_AND = 1'b1
  } ifm_comb_t;

  typedef enum logic [0:0] {
    IFM_SW_MANUAL = 1'b0,
    IFM_SW_AUTO   = 1'b1
  } ifm_swmode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ifm_apb_req_t;

  typedef struct packed {
    logic [NCOND-1:0] enable;
    logic [7:0]       hold;
    logic [7:0]       vhold;
    logic [7:0]       release_units;
    ifm_comb_t        comb;
  } ifm_cfg_t;

endpackage

// File: rtl/ifm_qual.sv
// Per-input condition qualifier, combiner and release timer
module ifm_qual (
  // Clock and reset
  input  wire logic                     i_core_clk,
  input  wire logic                     i_nrst,
  // Conditions and setup
  input  wire logic [ifm_pkg::NCOND-1:0] i_cond,
  input  wire ifm_pkg::ifm_cfg_t        i_cfg,
  // Time bases
  input  wire logic                     i_dur_tick,
  input  wire logic                     i_rel_tick,
  // Result
  output logic                          o_fault
);

  typedef struct packed {
    logic [ifm_pkg::NAUD:0][7:0] cnt;   // Audio counters plus invalid video
    logic [7:0]                  rel;
    logic                        fault;
  } ifm_qual_st_t;

  ifm_qual_st_t st;
  ifm_qual_st_t next_st;
  logic [ifm_pkg::NCOND-1:0] qual;
  logic [ifm_pkg::NCOND-1:0] item;
  logic                      raw;

  // Persistence counters, qualified items and fault release
  always_comb begin
    next_st = st;
    qual    = i_cond;                    // Unqualified items pass straight
    for (int k = 0; k <= ifm_pkg::NAUD; k++) begin
      logic       c;
      logic [7:0] lim;
      c   = (k == ifm_pkg::NAUD) ? i_cond[ifm_pkg::C_VINVALID]
                                 : i_cond[ifm_pkg::C_AUD_FIRST + k];
      lim = (k == ifm_pkg::NAUD) ? i_cfg.vhold : i_cfg.hold;
      if (!c) begin
        next_st.cnt[k] = 8'h00;
      end else if (i_dur_tick && st.cnt[k] != ifm_pkg::CNT_MAX) begin
        next_st.cnt[k] = st.cnt[k] + 8'h01;
      end
      if (k == ifm_pkg::NAUD) begin
        qual[ifm_pkg::C_VINVALID] = c && (st.cnt[k] >= lim);
      end else begin
        qual[ifm_pkg::C_AUD_FIRST + k] = c && (st.cnt[k] >= lim);
      end
    end
    item = qual & i_cfg.enable;
    if (i_cfg.comb == ifm_pkg::IFM_COMB_AND) begin
      raw = (item == i_cfg.enable) && (|i_cfg.enable);
    end else begin
      raw = |item;
    end
    if (raw) begin
      next_st.fault = 1'b1;
      next_st.rel   = 8'h00;
    end else if (st.fault) begin
      if (st.rel >= i_cfg.release_units) begin
        next_st.fault = 1'b0;
      end else if (i_rel_tick) begin
        next_st.rel = st.rel + 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_fault = st.fault;

endmodule

// File: rtl/ifm_top.sv
// Input fault monitor top: APB registers, time base, auto switch
module ifm_top #(
  parameter int UNIT_CYCLES = ifm_pkg::UNIT_CYCLES
) (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_nrst,
  // APB slave
  input  wire ifm_pkg::ifm_apb_req_t     i_apb,
  output logic [31:0]                    o_prdata,
  output logic                           o_pready,
  output logic                           o_pslverr,
  // Condition detectors, one vector per input
  input  wire logic [ifm_pkg::NCOND-1:0] i_in1_cond,
  input  wire logic [ifm_pkg::NCOND-1:0] i_in2_cond,
  // Frame pulse from video timing
  input  wire logic                      i_frame_pulse,
  // Router side
  output logic                           o_in1_fault,
  output logic                           o_in2_fault,
  output logic                           o_route_sel
);

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    ifm_pkg::ifm_cfg_t    cfg1;
    ifm_pkg::ifm_cfg_t    cfg2;
    ifm_pkg::ifm_swmode_t switch_mode_select;
    logic                 mansel;
    logic                 asi;
    logic [31:0]          unit_cnt;
    logic                 unit_tick;
    logic                 route;
    logic [31:0]          prdata;
  } ifm_top_st_t;

  ifm_top_st_t st;
  ifm_top_st_t next_st;
  logic        f1;
  logic        f2;
  logic        dur_tick;
  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd;

  // -------------------------------------------------------------------
  // Address decode helpers
  // -------------------------------------------------------------------
  function automatic logic [7:0] in_addr(input int n, input logic [7:0] off);
    in_addr = 8'(ifm_pkg::A_IN_BASE + 8'(n) * ifm_pkg::A_IN_STEP + off);
  endfunction

  function automatic logic [31:0] time_word(input ifm_pkg::ifm_cfg_t c);
    time_word = '0;
    time_word[ifm_pkg::F_HOLD  +: 8] = c.hold;
    time_word[ifm_pkg::F_VHOLD +: 8] = c.vhold;
    time_word[ifm_pkg::F_REL   +: 8] = c.release_units;
    time_word[ifm_pkg::F_LOGIC]      = c.comb;
  endfunction

  function automatic ifm_pkg::ifm_cfg_t cfg_reset();
    cfg_reset               = '0;          // All enables off
    cfg_reset.hold          = ifm_pkg::HOLD_RST;
    cfg_reset.vhold         = ifm_pkg::VHOLD_RST;
    cfg_reset.release_units = ifm_pkg::RELEASE_RST;
    cfg_reset.comb          = ifm_pkg::IFM_COMB_OR;
  endfunction

  // Write one input's setup registers
  function automatic ifm_pkg::ifm_cfg_t cfg_write(
    input ifm_pkg::ifm_cfg_t c,
    input int                n,
    input logic [7:0]        a,
    input logic [31:0]       d
  );
    cfg_write = c;
    if (a == in_addr(n, ifm_pkg::A_EN_LO)) begin
      cfg_write.enable[31:0] = d;
    end else if (a == in_addr(n, ifm_pkg::A_EN_HI)) begin
      cfg_write.enable[ifm_pkg::NCOND-1:32] = d[ifm_pkg::NCOND-33:0];
    end else if (a == in_addr(n, ifm_pkg::A_TIME)) begin
      cfg_write.hold          = d[ifm_pkg::F_HOLD  +: 8];
      cfg_write.vhold         = d[ifm_pkg::F_VHOLD +: 8];
      cfg_write.release_units = d[ifm_pkg::F_REL   +: 8];
      cfg_write.comb = ifm_pkg::ifm_comb_t'(d[ifm_pkg::F_LOGIC]);
    end
  endfunction

  // Read one input's setup registers
  function automatic logic [31:0] cfg_read(
    input ifm_pkg::ifm_cfg_t c,
    input int                n,
    input logic [7:0]        a
  );
    cfg_read = '0;
    if (a == in_addr(n, ifm_pkg::A_EN_LO)) begin
      cfg_read = c.enable[31:0];
    end else if (a == in_addr(n, ifm_pkg::A_EN_HI)) begin
      cfg_read[ifm_pkg::NCOND-33:0] = c.enable[ifm_pkg::NCOND-1:32];
    end else if (a == in_addr(n, ifm_pkg::A_TIME)) begin
      cfg_read = time_word(c);
    end
  endfunction

  function automatic logic is_in_reg(input int n, input logic [7:0] a);
    is_in_reg = (a == in_addr(n, ifm_pkg::A_EN_LO)) ||
                (a == in_addr(n, ifm_pkg::A_EN_HI)) ||
                (a == in_addr(n, ifm_pkg::A_TIME));
  endfunction

  // -------------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------------
  assign acc = i_apb.psel && i_apb.penable;
  assign wr  = acc && i_apb.pwrite;
  assign hit = (i_apb.paddr == ifm_pkg::A_CTRL) ||
               (i_apb.paddr == ifm_pkg::A_STATUS) ||
               is_in_reg(0, i_apb.paddr) || is_in_reg(1, i_apb.paddr);

  // Read mux
  always_comb begin
    rd = '0;
    if (i_apb.paddr == ifm_pkg::A_CTRL) begin
      rd[ifm_pkg::F_SWITCH_MODE_SELECT]   = st.switch_mode_select;
      rd[ifm_pkg::F_MANSEL] = st.mansel;
      rd[ifm_pkg::F_ASI]    = st.asi;
    end else if (i_apb.paddr == ifm_pkg::A_STATUS) begin
      rd[0] = f1;
      rd[1] = f2;
      rd[2] = st.route;
    end else begin
      rd = cfg_read(st.cfg1, 0, i_apb.paddr) |
           cfg_read(st.cfg2, 1, i_apb.paddr);
    end
  end

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Register writes and read data capture
    if (wr && hit) begin
      if (i_apb.paddr == ifm_pkg::A_CTRL) begin
        next_st.switch_mode_select =
          ifm_pkg::ifm_swmode_t'(i_apb.pwdata[ifm_pkg::F_SWITCH_MODE_SELECT]);
        next_st.mansel = i_apb.pwdata[ifm_pkg::F_MANSEL];
        next_st.asi    = i_apb.pwdata[ifm_pkg::F_ASI];
      end
      next_st.cfg1 = cfg_write(st.cfg1, 0, i_apb.paddr, i_apb.pwdata);
      next_st.cfg2 = cfg_write(st.cfg2, 1, i_apb.paddr, i_apb.pwdata);
    end
    if (i_apb.psel && !i_apb.penable && !i_apb.pwrite) begin
      next_st.prdata = rd;
    end
    // 50 ms unit tick
    next_st.unit_tick = 1'b0;
    if (st.unit_cnt >= 32'(UNIT_CYCLES - 1)) begin
      next_st.unit_cnt  = '0;
      next_st.unit_tick = 1'b1;
    end else begin
      next_st.unit_cnt = st.unit_cnt + 32'h0000_0001;
    end
    // Route selection
    if (st.switch_mode_select == ifm_pkg::IFM_SW_AUTO) begin
      if (!st.route && f1 && !f2) begin
        next_st.route = 1'b1;
      end else if (st.route && f2 && !f1) begin
        next_st.route = 1'b0;
      end
    end else begin
      next_st.route = st.mansel;
    end
  end

  // State register
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      st      <= '0;
      st.cfg1 <= cfg_reset();
      st.cfg2 <= cfg_reset();
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------
  // Per-input fault monitors
  // -------------------------------------------------------------------
  // Duration unit: frames in video mode, 50 ms in ASI mode
  assign dur_tick = st.asi ? st.unit_tick : i_frame_pulse;

  ifm_qual u_in1 (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_cond     (i_in1_cond),
    .i_cfg      (st.cfg1),
    .i_dur_tick (dur_tick),
    .i_rel_tick (st.unit_tick),
    .o_fault    (f1)
  );

  ifm_qual u_in2 (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .i_cond     (i_in2_cond),
    .i_cfg      (st.cfg2),
    .i_dur_tick (dur_tick),
    .i_rel_tick (st.unit_tick),
    .o_fault    (f2)
  );

  // -------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------
  assign o_prdata    = st.prdata;
  assign o_pready    = 1'b1;
  assign o_pslverr   = acc && !hit;
  assign o_in1_fault = f1;
  assign o_in2_fault = f2;
  assign o_route_sel = st.route;

endmodule

// File: verif/ifm_det_model.sv
// Detector side model: condition levels and frame pulse
module ifm_det_model #(
  parameter int FRAME_CYCLES = 4
) (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_nrst,
  // Requested conditions
  input  wire logic [ifm_pkg::NCOND-1:0] i_req1,
  input  wire logic [ifm_pkg::NCOND-1:0] i_req2,
  // Toward the monitor
  output logic      [ifm_pkg::NCOND-1:0] o_in1_cond,
  output logic      [ifm_pkg::NCOND-1:0] o_in2_cond,
  output logic                           o_frame_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;

  // Levels change on the clock; frame pulse one cycle wide
  always_ff @(posedge i_core_clk) begin
    o_in1_cond    <= i_req1;
    o_in2_cond    <= i_req2;
    cnt           <= (!i_nrst || cnt == FRAME_CYCLES - 1) ? 0 : cnt + 1;
    o_frame_pulse <= i_nrst && cnt == FRAME_CYCLES - 1;
  end
endmodule

// File: verif/ifm_props.sv
// Checker for the input fault monitor top ports
module ifm_props #(
  parameter int UNIT_CYCLES = 10
) (
  // Clock and reset
  input  wire logic                      i_core_clk,
  input  wire logic                      i_nrst,
  // APB slave
  input  wire ifm_pkg::ifm_apb_req_t     i_apb,
  input  wire logic [31:0]               o_prdata,
  input  wire logic                      o_pready,
  input  wire logic                      o_pslverr,
  // Detectors and router side
  input  wire logic [ifm_pkg::NCOND-1:0] i_in1_cond,
  input  wire logic [ifm_pkg::NCOND-1:0] i_in2_cond,
  input  wire logic                      i_frame_pulse,
  input  wire logic                      o_in1_fault,
  input  wire logic                      o_in2_fault,
  input  wire logic                      o_route_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // Helper logic
  // -------------------------------------------------------------------
  logic [1:0] ctrl_sh;
  logic       acc;
  logic       setup;
  logic       mapped;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // Phase decode and address map
  assign acc    = i_apb.psel && i_apb.penable;
  assign setup  = i_apb.psel && !i_apb.penable;
  assign mapped = i_apb.paddr inside {8'h00, 8'h04, 8'h10, 8'h14,
                                      8'h18, 8'h20, 8'h24, 8'h28};

  // Shadow of auto mode and manual select
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      ctrl_sh <= 2'h0;
    end else if (acc && i_apb.pwrite && i_apb.paddr == 8'h00) begin
      ctrl_sh <= i_apb.pwdata[1:0];
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  a_pready_high: assert property (o_pready)
    else $error("pready low");
  a_err_map: assert property (acc |-> o_pslverr == !mapped)
    else $error("pslverr wrong in access phase");
  a_err_idle: assert property (!acc |-> !o_pslverr)
    else $error("pslverr outside access phase");
  a_rd_zero: assert property (
    setup && !i_apb.pwrite && !mapped |=> o_prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_rd_status: assert property (
    setup && !i_apb.pwrite && i_apb.paddr == 8'h04 |=>
      o_prdata[2:0] == $past({o_route_sel, o_in2_fault, o_in1_fault}))
    else $error("status read wrong");
  a_cause_one: assert property (
    $rose(o_in1_fault) |-> $past(i_in1_cond) != '0)
    else $error("fault 1 rose with no condition");
  a_cause_two: assert property (
    $rose(o_in2_fault) |-> $past(i_in2_cond) != '0)
    else $error("fault 2 rose with no condition");
  a_route_manual: assert property (
    $past(!ctrl_sh[0]) |-> o_route_sel == $past(ctrl_sh[1]))
    else $error("manual route wrong");
  a_route_auto: assert property (
    ctrl_sh[0] && !o_route_sel && o_in1_fault && !o_in2_fault |->
      ##[1:2] (o_route_sel || !ctrl_sh[0] || o_in2_fault || !o_in1_fault))
    else $error("auto route stayed on faulted input");
endmodule

bind ifm_top ifm_props #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_apb(i_apb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_in1_cond(i_in1_cond), .i_in2_cond(i_in2_cond),
  .i_frame_pulse(i_frame_pulse), .o_in1_fault(o_in1_fault),
  .o_in2_fault(o_in2_fault), .o_route_sel(o_route_sel));

// File: verif/testbench.sv
// Self-checking bench for the input fault monitor
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------------
  // Signals
  // -------------------------------------------------------------------
  localparam int UNIT = 10;
  logic                  i_core_clk;
  logic                  i_nrst;
  ifm_pkg::ifm_apb_req_t apb;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [33:0]           req1;
  logic [33:0]           req2;
  logic [33:0]           cond1;
  logic [33:0]           cond2;
  logic                  frame;
  logic                  f1;
  logic                  f2;
  logic                  route;
  int                    n_fail = 0;
  int                    compares = 0;
  int                    c;

  ifm_top #(.UNIT_CYCLES(UNIT)) uut (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .i_apb(apb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_in1_cond(cond1), .i_in2_cond(cond2),
    .i_frame_pulse(frame), .o_in1_fault(f1), .o_in2_fault(f2),
    .o_route_sel(route));
  ifm_det_model #(.FRAME_CYCLES(4)) u_det (.i_core_clk(i_core_clk),
    .i_nrst(i_nrst), .i_req1(req1), .i_req2(req2), .o_in1_cond(cond1),
    .o_in2_cond(cond2), .o_frame_pulse(frame));

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb_x(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
    int n;
    n = 0;
    @(posedge i_core_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_core_clk);
    apb.penable <= 1'b1;
    @(posedge i_core_clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge i_core_clk);
    end
    if (pready !== 1'b1) begin
      n_fail++;
    end
    q = prdata;
    e = pslverr;
    apb <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb_x(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic xe);
    logic [31:0] q;
    logic        e;
    apb_x(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask

  function automatic logic [7:0] ra(int inp, logic [7:0] off);
    return 8'(int'(ifm_pkg::A_IN_BASE)
              + int'(ifm_pkg::A_IN_STEP) * (inp - 1) + int'(off));
  endfunction

  function automatic logic [31:0] tv(logic [7:0] h, logic [7:0] v,
                                     logic [7:0] r, logic cmb);
    return {7'h00, cmb, r, v, h};
  endfunction

  task automatic set_en(int inp, logic [33:0] m);
    wr(ra(inp, ifm_pkg::A_EN_LO), m[31:0]);
    wr(ra(inp, ifm_pkg::A_EN_HI), {30'h0, m[33:32]});
  endtask

  // Count falling edges until the fault output reaches a level
  task automatic wait_f(int inp, logic lvl, int lim, output int n);
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while ((inp == 1 ? f1 : f2) !== lvl && n < lim);
  endtask

  // -------------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------------
  task automatic t_reset;
    rd_chk(ifm_pkg::A_CTRL, 32'h0, 1'b0);
    rd_chk(ra(1, ifm_pkg::A_TIME), 32'h00141E1E, 1'b0);
    rd_chk(ra(2, ifm_pkg::A_TIME), 32'h00141E1E, 1'b0);
    rd_chk(ra(1, ifm_pkg::A_EN_LO), 32'h0, 1'b0);
    rd_chk(ra(2, ifm_pkg::A_EN_HI), 32'h0, 1'b0);
    rd_chk(8'h0C, 32'h0, 1'b1);
    @(posedge i_core_clk);
    req1 <= '1;
    req2 <= '1;
    repeat (20) @(negedge i_core_clk);
    chk({30'h0, f2, f1}, 32'h0);
    @(posedge i_core_clk);
    req1 <= '0;
    req2 <= '0;
  endtask

  task automatic t_loss;
    wr(ra(1, ifm_pkg::A_TIME), tv(8'h1E, 8'h1E, 8'h02, 1'b0));
    set_en(1, 34'h1);
    @(posedge i_core_clk);
    req1 <= 34'h1;
    wait_f(1, 1'b1, 20, c);
    chk(32'(c), 32'h3);
    chk({31'h0, f2}, 32'h0);
    @(posedge i_core_clk);
    req1 <= '0;
    wait_f(1, 1'b0, 40, c);
    chk({31'h0, c > 10 && c <= 24}, 32'h1);
  endtask

  // Audio items and invalid video on input 1, each qualified
  task automatic t_audio(logic asi);
    int lo;
    for (int b = asi ? 4 : 3; b < 24; b++) begin
      lo = asi ? 12 : (b == 3 ? 20 : 5);
      set_en(1, 34'h1 << b);
      @(posedge i_core_clk);
      req1 <= 34'h1 << b;
      wait_f(1, 1'b1, 40, c);
      chk({31'h0, c >= lo && c <= lo + 14}, 32'h1);
      chk({31'h0, f1}, 32'h1);
      @(posedge i_core_clk);
      req1 <= '0;
      wait_f(1, 1'b0, 20, c);
      chk({31'h0, f1}, 32'h0);
      if (asi) break;
    end
  endtask

  // Unqualified items on input 2
  task automatic t_plain;
    int items[12] = '{1, 2, 24, 25, 26, 27, 28, 29, 30, 31, 32, 33};
    wr(ra(2, ifm_pkg::A_TIME), tv(8'h1E, 8'h1E, 8'h00, 1'b0));
    foreach (items[i]) begin
      set_en(2, 34'h1 << items[i]);
      @(posedge i_core_clk);
      req2 <= 34'h1 << items[i];
      wait_f(2, 1'b1, 20, c);
      chk(32'(c), 32'h3);
      @(posedge i_core_clk);
      req2 <= '0;
      wait_f(2, 1'b0, 20, c);
      chk({31'h0, f2}, 32'h0);
    end
  endtask

  task automatic t_and;
    wr(ra(2, ifm_pkg::A_TIME), tv(8'h1E, 8'h1E, 8'h00, 1'b1));
    set_en(2, 34'h3);
    @(posedge i_core_clk);
    req2 <= 34'h1;
    wait_f(2, 1'b1, 10, c);
    chk({31'h0, f2}, 32'h0);
    @(posedge i_core_clk);
    req2 <= 34'h3;
    wait_f(2, 1'b1, 10, c);
    chk(32'(c), 32'h3);
    @(posedge i_core_clk);
    req2 <= '0;
    wait_f(2, 1'b0, 20, c);
    chk({31'h0, f2}, 32'h0);
  endtask

  task automatic t_route;
    wr(ifm_pkg::A_CTRL, 32'h2);
    repeat (2) @(negedge i_core_clk);
    chk({31'h0, route}, 32'h1);
    wr(ifm_pkg::A_CTRL, 32'h0);
    wr(ra(2, ifm_pkg::A_TIME), tv(8'h1E, 8'h1E, 8'h00, 1'b0));
    wr(ra(1, ifm_pkg::A_TIME), tv(8'h02, 8'h06, 8'h00, 1'b0));
    set_en(1, 34'h1);
    set_en(2, 34'h1);
    wr(ifm_pkg::A_CTRL, 32'h1);
    repeat (2) @(negedge i_core_clk);
    chk({31'h0, route}, 32'h0);
    @(posedge i_core_clk);
    req1 <= 34'h1;
    repeat (8) @(negedge i_core_clk);
    chk({31'h0, route}, 32'h1);
    @(posedge i_core_clk);
    req2 <= 34'h1;
    repeat (8) @(negedge i_core_clk);
    rd_chk(ifm_pkg::A_STATUS, 32'h7, 1'b0);
    @(posedge i_core_clk);
    req1 <= '0;
    repeat (8) @(negedge i_core_clk);
    chk({30'h0, route, f1}, 32'h0);
    @(posedge i_core_clk);
    req2 <= '0;
    wr(ifm_pkg::A_CTRL, 32'h4);
  endtask

  // -------------------------------------------------------------------
  // Clock, sequence, watchdog
  // -------------------------------------------------------------------
  task automatic report_and_stop;
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  initial begin
    i_nrst = 1'b0;
    apb = '0;
    req1 = '0;
    req2 = '0;
    repeat (3) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    t_reset();
    t_loss();
    wr(ra(1, ifm_pkg::A_TIME), tv(8'h02, 8'h06, 8'h00, 1'b0));
    t_audio(1'b0);
    t_plain();
    t_and();
    t_route();
    t_audio(1'b1);
    report_and_stop();
  end

  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule
